// >>> src/dira_pkg.sv
/*
  Package for the converter indirect register block: SFR addresses, select
  values, control field positions, reset values and load codes.
  Assumes an 8-bit special-function-register bus with one-cycle strobes.
*/
package dira_pkg;

  localparam logic [7:0] SFR_LOW_PORT  = 8'hb5;
  localparam logic [7:0] SFR_HIGH_PORT = 8'hb6;
  localparam logic [7:0] SFR_SELECT    = 8'hb7;

  localparam logic [7:0] SEL_CH0   = 8'h00;
  localparam logic [7:0] SEL_CTRL  = 8'h04;
  localparam logic [7:0] SEL_CTRL2 = 8'h05;
  localparam logic [7:0] SEL_LOAD  = 8'h06;

  localparam int OC_FLAG_BIT  = 7;
  localparam int OC_EN_BIT    = 6;
  localparam int IOFF_BIT     = 5;
  localparam int SINK_BIT     = 4;
  localparam int REF_BIT      = 2;
  localparam int MODE_LSB     = 0;

  localparam logic [7:0] CTRL01_RESET = 8'h63;
  localparam logic [7:0] CTRL23_RESET = 8'h03;
  localparam logic [7:0] LOAD_RESET   = 8'h00;
  localparam logic [7:0] SEL_RESET    = 8'h00;
  localparam logic [15:0] CODE_RESET  = 16'h0000;
  localparam logic [7:0] CTRL01_MASK  = 8'hf7;
  localparam logic [7:0] CTRL23_MASK  = 8'h07;

  localparam logic [1:0] OC_TICKS = 2'h3;

  typedef enum logic [1:0] {
    DIRA_LOAD_DIRECT = 2'b00,
    DIRA_LOAD_TICK   = 2'b01,
    DIRA_LOAD_HALF   = 2'b10,
    DIRA_LOAD_SYNC   = 2'b11
  } dira_load_t;

  typedef enum logic [1:0] {
    DIRA_MODE_NORMAL = 2'b00,
    DIRA_MODE_PD_1K  = 2'b01,
    DIRA_MODE_PD_100K = 2'b10,
    DIRA_MODE_PD_HIZ = 2'b11
  } dira_mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dira_sfr_req_t;

  typedef struct packed {
    logic       volt_on;
    logic [1:0] pd_mode;
    logic       ref_ext;
    logic       cur_on;
    logic       cur_sink;
  } dira_chan_out_t;

endpackage : dira_pkg

// >>> src/dira_code_mem.sv
/*
  Holds the staged 16-bit channel codes written through the byte ports.
  Assumes the parent decodes writes; read data come out of a register.
*/
module dira_code_mem #(
  parameter int NCH = 4
) (
  input  wire logic                   clock_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  input  wire logic                   wr_lo_i,
  input  wire logic                   wr_hi_i,
  input  wire logic [1:0]             waddr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic [1:0]             raddr_i,
  output logic      [15:0]            rdata_o,
  output logic      [NCH*16-1:0]      all_o
);

  logic [15:0] mem_q [NCH];

  for (genvar g = 0; g < NCH; g++) begin : g_word
    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        mem_q[g] <= dira_pkg::CODE_RESET;
      end else if (ce_i && waddr_i == 2'(g)) begin
        if (wr_lo_i) mem_q[g][7:0] <= wdata_i;
        if (wr_hi_i) mem_q[g][15:8] <= wdata_i;
      end
    end
    assign all_o[g*16 +: 16] = mem_q[g];
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= dira_pkg::CODE_RESET;
    end else if (ce_i) begin
      rdata_o <= (int'(raddr_i) < NCH) ? mem_q[raddr_i] : dira_pkg::CODE_RESET;
    end
  end

endmodule : dira_code_mem

// >>> src/dira_top.sv
/*
  Converter indirect register block: select register, low and high byte
  ports, staged and live channel codes, control and load registers, and
  channel 0 overcurrent protection.
  Assumes an SFR bus with one-cycle rd/wr strobes, read data one cycle
  after the strobe, and a one-cycle millisecond and half-ms tick.
*/
module dira_top #(
  parameter int NCH = 4
) (
  input  wire logic                         clock_i,
  input  wire logic                         rst_i,
  input  wire logic                         ce_i,
  input  wire dira_pkg::dira_sfr_req_t      sfr_i,
  output logic      [7:0]                   sfr_rdata_o,
  input  wire logic                         millisecond_tick_i,
  input  wire logic                         half_millisecond_tick_i,
  input  wire logic                         over_range_i,
  output logic      [NCH*16-1:0]            channel_code_o,
  output dira_pkg::dira_chan_out_t [NCH-1:0] chan_out_o
);

  logic [7:0]  select_value_q;
  logic [7:0]  ctrl_q [4];
  logic [7:0]  load_control_q;
  logic [NCH*16-1:0] staged;
  logic [15:0] code_rdata;
  logic [1:0]  oc_cnt_q;
  logic        oc_trip_q;
  logic        or_s1_q;
  logic        or_s2_q;
  logic        or_s3_q;
  logic        or_hold_q;
  logic [1:0]  rd_kind_q;
  logic [7:0]  rd_ctl_q;
  logic        wr_lo;
  logic        wr_hi;
  logic        wr_sel;
  logic        code_sel;
  logic        sel_ok;
  logic        over_now;
  logic        flag_clear;

  // Narrow builds leave select 05h and the code selects from NCH up to 03h unmapped
  assign code_sel = select_value_q < dira_pkg::SEL_CTRL
                    && int'(select_value_q) < NCH;
  assign sel_ok   = (select_value_q == dira_pkg::SEL_CTRL2) ? (NCH == 4) : 1'b1;
  assign wr_lo    = ce_i && sfr_i.wr && sfr_i.addr == dira_pkg::SFR_LOW_PORT;
  assign wr_hi    = ce_i && sfr_i.wr && sfr_i.addr == dira_pkg::SFR_HIGH_PORT;
  assign wr_sel   = ce_i && sfr_i.wr && sfr_i.addr == dira_pkg::SFR_SELECT;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      select_value_q <= dira_pkg::SEL_RESET;
    end else if (wr_sel) begin
      select_value_q <= sfr_i.wdata;
    end
  end

  dira_code_mem #(
    .NCH (NCH)
  ) u_mem (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .wr_lo_i (wr_lo && code_sel),
    .wr_hi_i (wr_hi && code_sel),
    .waddr_i (select_value_q[1:0]),
    .wdata_i (sfr_i.wdata),
    .raddr_i (select_value_q[1:0]),
    .rdata_o (code_rdata),
    .all_o   (staged)
  );

  // Raw over-range is an analog comparator, so it crosses into this domain
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      or_s1_q   <= 1'b0;
      or_s2_q   <= 1'b0;
      or_s3_q   <= 1'b0;
      or_hold_q <= 1'b0;
    end else if (ce_i) begin
      or_s1_q   <= over_range_i;
      or_s2_q   <= or_s1_q;
      or_s3_q   <= or_s2_q;
      or_hold_q <= over_now;
    end
  end
  // A change counts only once the last two stages agree, so a one-cycle
  // glitch can neither start nor break a run of overcurrent ticks
  assign over_now = (or_s2_q == or_s3_q) ? or_s2_q : or_hold_q;

  // Control registers; index 0/1 full, 2/3 reference and mode only
  for (genvar c = 0; c < 4; c++) begin : g_ctrl
    localparam logic [7:0] RST  = (c < 2) ? dira_pkg::CTRL01_RESET
                                          : dira_pkg::CTRL23_RESET;
    localparam logic [7:0] MASK = (c < 2) ? dira_pkg::CTRL01_MASK
                                          : dira_pkg::CTRL23_MASK;
    logic hit;
    assign hit = (c == 0) ? wr_lo && select_value_q == dira_pkg::SEL_CTRL :
                 (c == 1) ? wr_hi && select_value_q == dira_pkg::SEL_CTRL :
                 (c == 2) ? wr_lo && select_value_q == dira_pkg::SEL_CTRL2 && NCH == 4 :
                            wr_hi && select_value_q == dira_pkg::SEL_CTRL2 && NCH == 4;
    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        ctrl_q[c] <= RST;
      end else if (hit) begin
        // The flag bit is status; its write is handled by the trip logic
        ctrl_q[c] <= (sfr_i.wdata & MASK & 8'h7f) | (ctrl_q[c] & 8'h80);
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      load_control_q <= dira_pkg::LOAD_RESET;
    end else if (wr_lo && select_value_q == dira_pkg::SEL_LOAD) begin
      load_control_q <= (NCH == 4) ? sfr_i.wdata : {4'h0, sfr_i.wdata[3:0]};
    end
  end

  assign flag_clear = wr_lo && select_value_q == dira_pkg::SEL_CTRL
                      && !sfr_i.wdata[dira_pkg::OC_FLAG_BIT];

  // Counts consecutive millisecond ticks with overcurrent present
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      oc_cnt_q  <= 2'h0;
      oc_trip_q <= 1'b0;
    end else if (ce_i) begin
      if (!over_now) begin
        oc_cnt_q <= 2'h0;
      end else if (millisecond_tick_i && oc_cnt_q != dira_pkg::OC_TICKS) begin
        oc_cnt_q <= oc_cnt_q + 2'h1;
      end
      // Trip wins over a clear in the same cycle; clear fails while still over
      if (ctrl_q[0][dira_pkg::OC_EN_BIT] && over_now && millisecond_tick_i
          && oc_cnt_q == dira_pkg::OC_TICKS - 2'h1) begin
        oc_trip_q <= 1'b1;
      end else if (flag_clear && !over_now) begin
        oc_trip_q <= 1'b0;
      end else if (!ctrl_q[0][dira_pkg::OC_EN_BIT]) begin
        oc_trip_q <= 1'b0;
      end
    end
  end

  // Flag shows latched trip when enabled, raw comparator otherwise
  logic oc_flag;
  assign oc_flag = ctrl_q[0][dira_pkg::OC_EN_BIT] ? oc_trip_q : over_now;

  // Read path: codes come registered from memory, control bytes here
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_kind_q <= 2'h0;
      rd_ctl_q  <= 8'h00;
    end else if (ce_i) begin
      rd_kind_q <= 2'h0;
      rd_ctl_q  <= 8'h00;
      if (sfr_i.rd && sfr_i.addr == dira_pkg::SFR_SELECT) begin
        rd_kind_q <= 2'h3;
        rd_ctl_q  <= select_value_q;
      end else if (sfr_i.rd && sfr_i.addr == dira_pkg::SFR_LOW_PORT && sel_ok) begin
        rd_kind_q <= code_sel ? 2'h1 : 2'h3;
        case (select_value_q)
          dira_pkg::SEL_CTRL:  rd_ctl_q <= {oc_flag, ctrl_q[0][6:0]};
          dira_pkg::SEL_CTRL2: rd_ctl_q <= ctrl_q[2];
          dira_pkg::SEL_LOAD:  rd_ctl_q <= load_control_q;
          default:             rd_ctl_q <= 8'h00;
        endcase
      end else if (sfr_i.rd && sfr_i.addr == dira_pkg::SFR_HIGH_PORT && sel_ok) begin
        rd_kind_q <= code_sel ? 2'h2 : 2'h3;
        case (select_value_q)
          dira_pkg::SEL_CTRL:  rd_ctl_q <= ctrl_q[1];
          dira_pkg::SEL_CTRL2: rd_ctl_q <= ctrl_q[3];
          default:             rd_ctl_q <= 8'h00;
        endcase
      end
    end
  end

  always_comb begin
    case (rd_kind_q)
      2'h1:    sfr_rdata_o = code_rdata[7:0];
      2'h2:    sfr_rdata_o = code_rdata[15:8];
      2'h3:    sfr_rdata_o = rd_ctl_q;
      default: sfr_rdata_o = 8'h00;
    endcase
  end

  // Live codes per channel, moved from staging under each load code
  for (genvar k = 0; k < NCH; k++) begin : g_live
    logic [15:0] live_q;
    logic        pend_q;
    dira_pkg::dira_load_t lc;
    logic [7:0]  cv;
    logic        sync_wr;
    logic        fire;
    assign lc = dira_pkg::dira_load_t'(load_control_q[2*k +: 2]);
    assign cv = ctrl_q[k];
    assign sync_wr = wr_lo && select_value_q == dira_pkg::SEL_LOAD
                     && sfr_i.wdata[2*k +: 2] == 2'b11;
    always_comb begin
      case (lc)
        dira_pkg::DIRA_LOAD_TICK:  fire = pend_q && millisecond_tick_i;
        dira_pkg::DIRA_LOAD_HALF:  fire = pend_q && half_millisecond_tick_i;
        default:                   fire = 1'b0;
      endcase
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        live_q <= dira_pkg::CODE_RESET;
        pend_q <= 1'b0;
      end else if (ce_i) begin
        if (wr_lo && code_sel && select_value_q[1:0] == 2'(k)
            && lc == dira_pkg::DIRA_LOAD_DIRECT) begin
          live_q <= {staged[k*16+8 +: 8], sfr_i.wdata};
        end else if (sync_wr) begin
          live_q <= staged[k*16 +: 16];
        end else if (fire) begin
          live_q <= staged[k*16 +: 16];
        end
        if ((wr_lo || wr_hi) && code_sel && select_value_q[1:0] == 2'(k)) begin
          pend_q <= 1'b1;
        end else if (fire) begin
          pend_q <= 1'b0;
        end
      end
    end
    assign channel_code_o[k*16 +: 16] = live_q;
    logic normal;
    assign normal = cv[1:0] == dira_pkg::DIRA_MODE_NORMAL && !(k == 0 && oc_trip_q);
    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        chan_out_o[k] <= '{volt_on: 1'b0, pd_mode: 2'b11, ref_ext: 1'b0,
                           cur_on: 1'b0, cur_sink: 1'b0};
      end else if (ce_i) begin
        chan_out_o[k].volt_on  <= normal;
        chan_out_o[k].pd_mode  <= (k == 0 && oc_trip_q) ? 2'b11 : cv[1:0];
        chan_out_o[k].ref_ext  <= cv[dira_pkg::REF_BIT];
        chan_out_o[k].cur_on   <= (k < 2) && normal && !cv[dira_pkg::IOFF_BIT];
        chan_out_o[k].cur_sink <= (k < 2) && cv[dira_pkg::SINK_BIT];
      end
    end
  end

  // Steps of a trip: a third qualifying tick, then the latch
  sequence s_third_tick;
    ce_i && ctrl_q[0][dira_pkg::OC_EN_BIT] && over_now && millisecond_tick_i
    && oc_cnt_q == 2'h2;
  endsequence

  AST_TRIP_AFTER_TICKS: assert property (@(posedge clock_i) disable iff (rst_i)
    s_third_tick |=> oc_trip_q)
    else $error("overcurrent trip missed on third tick");
  AST_CLEAR_RULE: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && flag_clear && over_now && oc_trip_q |=> oc_trip_q)
    else $error("flag cleared while over range");
  AST_FLAG_CLEAR: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && flag_clear && !over_now |=> !oc_trip_q)
    else $error("flag not cleared by writing zero");
  AST_TRIP_OFF: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && oc_trip_q |=> !chan_out_o[0].volt_on && !chan_out_o[0].cur_on)
    else $error("tripped channel still driving");
  AST_SEL_WRITE: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_sel |=> select_value_q == $past(sfr_i.wdata))
    else $error("select register not written");
  AST_PD_MODE: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && ctrl_q[1][1:0] != 2'b00 |=> !chan_out_o[1].volt_on && !chan_out_o[1].cur_on)
    else $error("powered-down channel driving");
  AST_RAW_FLAG: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && sfr_i.rd && sfr_i.addr == dira_pkg::SFR_LOW_PORT
    && select_value_q == dira_pkg::SEL_CTRL && !ctrl_q[0][6]
    |=> sfr_rdata_o[7] == $past(over_now))
    else $error("flag not raw with detection off");
  AST_DETECT_OFF: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && !ctrl_q[0][dira_pkg::OC_EN_BIT] |=> !oc_trip_q)
    else $error("trip latched with detection off");
  AST_UNUSED_BIT: assert property (@(posedge clock_i) disable iff (rst_i)
    !ctrl_q[0][3] && !ctrl_q[1][3])
    else $error("unused control bit set");
  AST_UNMAPPED_RD: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && sfr_i.rd && sfr_i.addr == dira_pkg::SFR_HIGH_PORT
    && select_value_q >= dira_pkg::SEL_LOAD |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_DIRECT_LOAD: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && wr_lo && select_value_q == 8'h00 && load_control_q[1:0] == 2'b00
    |=> channel_code_o[7:0] == $past(sfr_i.wdata))
    else $error("direct load did not reach output");

endmodule : dira_top

// >>> dv/dira_timer_model.sv
/*
  Stand-in for the system timer: one-cycle ms and half-ms ticks on request.
  Assumes the bench calls its tasks in sequence, never two at once.
*/
module dira_timer_model (
  input  wire logic clock_i,
  output logic      ms_o,
  output logic      hms_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ms_o = 1'b0;
    hms_o = 1'b0;
  end
  // Ticks on demand, not free running, so a load can be held off at will
  task automatic ms_pulse();
    @(posedge clock_i) ms_o <= 1'b1;
    @(posedge clock_i) ms_o <= 1'b0;
  endtask : ms_pulse
  task automatic hms_pulse();
    @(posedge clock_i) hms_o <= 1'b1;
    @(posedge clock_i) hms_o <= 1'b0;
  endtask : hms_pulse
endmodule : dira_timer_model

// >>> dv/dira_top_tb.sv
/*
  Self-checking bench for the converter indirect register block.
  Assumes the four-channel build and the timer model beside it.
*/
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module dira_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] LO = dira_pkg::SFR_LOW_PORT;
  localparam logic [7:0] HI = dira_pkg::SFR_HIGH_PORT;
  localparam logic [7:0] SL = dira_pkg::SFR_SELECT;
  logic                          clock_i, rst_i, ce_i, ovr, ms, hms, rd_p;
  dira_pkg::dira_sfr_req_t       sfr;
  logic [7:0]                    rdata;
  logic [63:0]                   code;
  dira_pkg::dira_chan_out_t [3:0] co;
  logic [7:0]                    expq[$];
  logic [15:0]                   lf;
  int                            miscompares, num_checks, cyc;

  dira_top #(.NCH(4)) uut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .sfr_i(sfr),
    .sfr_rdata_o(rdata), .millisecond_tick_i(ms), .half_millisecond_tick_i(hms),
    .over_range_i(ovr), .channel_code_o(code), .chan_out_o(co));
  dira_timer_model tmr (.clock_i(clock_i), .ms_o(ms), .hms_o(hms));

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nxt

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i) sfr <= {w, ~w, a, v};
    @(posedge clock_i) sfr <= '0;
  endtask : bus
  task automatic wreg(input logic [7:0] s, input logic [7:0] p, input logic [7:0] v);
    bus(1'b1, SL, s);
    bus(1'b1, p, v);
  endtask : wreg
  task automatic rreg(input logic [7:0] s, input logic [7:0] p, input logic [7:0] e);
    bus(1'b1, SL, s);
    expq.push_back(e);
    bus(1'b0, p, 8'h00);
  endtask : rreg
  // Outputs are registered behind the write, so give them a few edges
  task automatic settle();
    repeat (3) @(posedge clock_i);
    #1;
  endtask : settle
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  // Read data stands only in the cycle after the strobe is taken
  always @(posedge clock_i) begin : mon
    logic [7:0] e;
    if (rd_p) begin
      e = expq.pop_front();
      `CHK(rdata, e)
    end
    rd_p = sfr.rd & ce_i;
  end

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    ce_i = 1'b1;
    ovr = 1'b0;
    rst_i = 1'b1;
    sfr = '0;
    rd_p = 1'b0;
    lf = 16'd23275;
    miscompares = 0;
    num_checks = 0;
    cyc = 0;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int s = 0; s < 8; s++) begin
      rreg(s[7:0], LO, s == 4 ? 8'h63 : s == 5 ? 8'h03 : 8'h00);
      rreg(s[7:0], HI, s == 4 ? 8'h63 : s == 5 ? 8'h03 : 8'h00);
    end
    wreg(8'h07, LO, 8'hff);
    wreg(8'h06, HI, 8'hff);
    rreg(8'h07, LO, 8'h00);
    rreg(8'h06, HI, 8'h00);
    rreg(8'h06, LO, 8'h00);
    $display("reset and unmapped test done");
    // Downward so that channel 0 holds the last random code
    for (int k = 3; k >= 0; k--) begin
      lf = nxt(lf);
      wreg(k[7:0], HI, lf[15:8]);
      wreg(k[7:0], LO, lf[7:0]);
      rreg(k[7:0], HI, lf[15:8]);
      rreg(k[7:0], LO, lf[7:0]);
      settle();
      `CHK(code[k*16 +: 16], lf)
    end
    $display("code test done");
    wreg(8'h06, LO, 8'h01);
    wreg(8'h00, HI, 8'h12);
    wreg(8'h00, LO, 8'h34);
    settle();
    `CHK(code[15:0], lf)
    tmr.ms_pulse();
    settle();
    `CHK(code[15:0], 16'h1234)
    wreg(8'h06, LO, 8'h02);
    wreg(8'h00, HI, 8'h56);
    wreg(8'h00, LO, 8'h78);
    tmr.ms_pulse();
    settle();
    `CHK(code[15:0], 16'h1234)
    tmr.hms_pulse();
    settle();
    `CHK(code[15:0], 16'h5678)
    wreg(8'h00, HI, 8'h9a);
    wreg(8'h00, LO, 8'hbc);
    wreg(8'h06, LO, 8'h03);
    settle();
    `CHK(code[15:0], 16'h9abc)
    rreg(8'h06, LO, 8'h03);
    wreg(8'h06, LO, 8'h00);
    $display("load test done");
    wreg(8'h04, LO, 8'h54);
    settle();
    `CHK(co[0], 6'b100111)
    wreg(8'h04, LO, 8'h5c);
    rreg(8'h04, LO, 8'h54);
    wreg(8'h04, LO, 8'h74);
    settle();
    `CHK(co[0][5:1], 5'b10010)
    for (int m = 1; m < 4; m++) begin
      wreg(8'h04, LO, 8'h54 | m[7:0]);
      settle();
      `CHK(co[0][5:1], {1'b0, m[1:0], 2'b10})
    end
    wreg(8'h04, HI, 8'h0f);
    rreg(8'h04, HI, 8'h07);
    wreg(8'h05, LO, 8'hff);
    rreg(8'h05, LO, 8'h07);
    rreg(8'h05, HI, 8'h03);
    settle();
    `CHK(co[1], 6'b011100)
    `CHK(co[2], 6'b011100)
    `CHK(co[3], 6'b011000)
    $display("control test done");
    wreg(8'h04, LO, 8'h40);
    @(posedge clock_i) ovr <= 1'b1;
    repeat (5) @(posedge clock_i);
    tmr.ms_pulse();
    tmr.ms_pulse();
    rreg(8'h04, LO, 8'h40);
    tmr.ms_pulse();
    settle();
    `CHK(co[0][5:1], 5'b01100)
    rreg(8'h04, LO, 8'hc0);
    rreg(8'h00, LO, 8'hbc);
    wreg(8'h04, LO, 8'h40);
    rreg(8'h04, LO, 8'hc0);
    @(posedge clock_i) ovr <= 1'b0;
    repeat (5) @(posedge clock_i);
    wreg(8'h04, LO, 8'h40);
    settle();
    rreg(8'h04, LO, 8'h40);
    `CHK(co[0][5:1], 5'b10001)
    wreg(8'h04, LO, 8'h00);
    @(posedge clock_i) ovr <= 1'b1;
    repeat (5) @(posedge clock_i);
    rreg(8'h04, LO, 8'h80);
    @(posedge clock_i) ovr <= 1'b0;
    $display("overcurrent test done");
    // A select write while the enable is low must not land
    @(posedge clock_i) ce_i <= 1'b0;
    bus(1'b1, SL, 8'h05);
    @(posedge clock_i) ce_i <= 1'b1;
    expq.push_back(8'h04);
    bus(1'b0, SL, 8'h00);
    $display("clock enable test done");
    repeat (4) @(posedge clock_i);
    end_sim();
  end
endmodule : dira_top_tb
